// [lbsm_monitor.sv]
// Link bring-up status monitor for source and sink sides of a lane core.
// Assumes PHY status inputs synchronous to clk_sys and the reset sequenced upstream.
//
// Overview of operation
// - Link up only after init done
// - Clock lock shown high while locked
// - Coding ready high after source reset
// - Bond done high once lanes bonded
// - Fast bond toggling flagged as fault
// - Transmit calibration busy shown high
// - Aligned high when all lanes aligned and coding ready
// - Sink coding ready high after reset
// - Checksum fault high on CRC mismatch
// - Coding fault on header/length/CRC error
// - Frame lock per lane after four words
// - Block-frame lock needs both locks
// - Per-lane data lock from CDR
// - Receive calibration busy shown high
`timescale 1ns/1ps
`default_nettype none

module lbsm_monitor (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire lbsm_pkg::lbsm_tx_phy_t tx_phy,
    input  wire lbsm_pkg::lbsm_rx_phy_t rx_phy,
    output var  lbsm_pkg::lbsm_tx_stat_t tx_stat,
    output var  lbsm_pkg::lbsm_rx_stat_t rx_stat
);

    // ****************************************
    // Source side state
    // ****************************************
    typedef enum logic [1:0] {
        LBSM_TX_INIT = 2'b00,
        LBSM_TX_WAIT = 2'b01,
        LBSM_TX_UP   = 2'b11
    } lbsm_tx_state_t;

    lbsm_tx_state_t          tx_state_reg,  tx_state_next;
    lbsm_pkg::lbsm_tx_stat_t tx_stat_reg,   tx_stat_next;
    logic                    bond_prev_reg, bond_prev_next;
    logic [7:0]              win_cnt_reg,   win_cnt_next;
    logic [3:0]              tgl_cnt_reg,   tgl_cnt_next;
    logic                    tx_ready_all;

    always_comb begin
        tx_ready_all   = tx_phy.pll_locked && tx_phy.pcs_ready
                         && tx_phy.bond_done && !tx_phy.cal_busy;
        tx_state_next  = tx_state_reg;
        unique case (tx_state_reg)
            LBSM_TX_INIT: begin
                if (tx_phy.pll_locked && !tx_phy.cal_busy) begin
                    tx_state_next = LBSM_TX_WAIT;
                end
            end
            LBSM_TX_WAIT: begin
                if (tx_ready_all) begin
                    tx_state_next = LBSM_TX_UP;
                end else if (!tx_phy.pll_locked || tx_phy.cal_busy) begin
                    tx_state_next = LBSM_TX_INIT;
                end
            end
            LBSM_TX_UP: begin
                if (!tx_ready_all) begin
                    tx_state_next = LBSM_TX_INIT;
                end
            end
            default: tx_state_next = LBSM_TX_INIT;
        endcase

        // Count bond edges within a fixed window
        bond_prev_next = tx_phy.bond_done;
        win_cnt_next   = (win_cnt_reg == lbsm_pkg::TOGGLE_WIN_LAST) ? 8'h00
                         : win_cnt_reg + 8'h01;
        tgl_cnt_next   = tgl_cnt_reg;
        if (win_cnt_reg == lbsm_pkg::TOGGLE_WIN_LAST) begin
            // Edge on the closing cycle still counts, in the next window
            tgl_cnt_next = (tx_phy.bond_done != bond_prev_reg) ? 4'h1 : 4'h0;
        end else if ((tx_phy.bond_done != bond_prev_reg) && (tgl_cnt_reg != 4'hf)) begin
            tgl_cnt_next = tgl_cnt_reg + 4'h1;
        end

        tx_stat_next.link_up_tx      = (tx_state_next == LBSM_TX_UP);
        tx_stat_next.tx_clk_locked   = tx_phy.pll_locked;
        tx_stat_next.tx_coding_ready = tx_phy.pcs_ready;
        tx_stat_next.tx_bond_done    = tx_phy.bond_done;
        tx_stat_next.tx_cal_busy     = tx_phy.cal_busy;
        // Sticky until the window closes, then re-evaluated
        tx_stat_next.tx_bond_unstable = (tgl_cnt_next >= lbsm_pkg::TOGGLE_LIMIT)
                         || (tx_stat_reg.tx_bond_unstable
                             && win_cnt_reg != lbsm_pkg::TOGGLE_WIN_LAST);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_state_reg  <= LBSM_TX_INIT;
            tx_stat_reg   <= '0;
            bond_prev_reg <= 1'b0;
            win_cnt_reg   <= 8'h00;
            tgl_cnt_reg   <= 4'h0;
        end else begin
            tx_state_reg  <= tx_state_next;
            tx_stat_reg   <= tx_stat_next;
            bond_prev_reg <= bond_prev_next;
            win_cnt_reg   <= win_cnt_next;
            tgl_cnt_reg   <= tgl_cnt_next;
        end
    end

    assign tx_stat = tx_stat_reg;

    // ****************************************
    // Sink side state
    // ****************************************
    logic [2:0]              sync_cnt_reg  [lbsm_pkg::LANES];
    logic [2:0]              sync_cnt_next [lbsm_pkg::LANES];
    lbsm_pkg::lbsm_rx_stat_t rx_stat_reg, rx_stat_next;
    logic [lbsm_pkg::LANES-1:0] flock;

    always_comb begin
        for (int i = 0; i < lbsm_pkg::LANES; i++) begin
            sync_cnt_next[i] = sync_cnt_reg[i];
            if (!rx_phy.cdr_data_locked[i] || rx_phy.sync_word_bad[i]) begin
                sync_cnt_next[i] = lbsm_pkg::SYNC_CNT_W0;
            end else if (rx_phy.sync_word_seen[i]
                         && sync_cnt_reg[i] != lbsm_pkg::SYNC_CNT_LOCK) begin
                sync_cnt_next[i] = sync_cnt_reg[i] + 3'h1;
            end
            flock[i] = (sync_cnt_next[i] == lbsm_pkg::SYNC_CNT_LOCK);
        end
        rx_stat_next.rx_frame_lock       = flock;
        rx_stat_next.rx_cdr_data_locked  = rx_phy.cdr_data_locked;
        rx_stat_next.rx_block_frame_lock = (&rx_phy.block_lock) && (&flock);
        rx_stat_next.rx_coding_ready     = rx_phy.pcs_ready;
        rx_stat_next.rx_cal_busy         = rx_phy.cal_busy;
        rx_stat_next.rx_checksum_fault   = rx_phy.checksum_fault;
        rx_stat_next.rx_coding_fault     = rx_phy.checksum_fault
                         || rx_phy.sync_hdr_err || rx_phy.mframe_len_err;
        rx_stat_next.rx_aligned          = (&rx_phy.cdr_data_locked) && (&flock)
                         && (&rx_phy.block_lock) && rx_phy.pcs_ready;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < lbsm_pkg::LANES; i++) begin
                sync_cnt_reg[i] <= 3'h0;
            end
            rx_stat_reg <= '0;
        end else begin
            for (int i = 0; i < lbsm_pkg::LANES; i++) begin
                sync_cnt_reg[i] <= sync_cnt_next[i];
            end
            rx_stat_reg <= rx_stat_next;
        end
    end

    assign rx_stat = rx_stat_reg;

    // ****************************************
    // Assertions
    // ****************************************
    link_up_needs_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_stat.link_up_tx |-> $past(tx_ready_all)) else $error("link up without ready");
    link_up_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tx_stat.link_up_tx) |-> $past(tx_state_reg) == LBSM_TX_WAIT)
        else $error("link up skipped init");
    clk_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 tx_stat.tx_clk_locked == $past(tx_phy.pll_locked)) else $error("lock mirror");
    tx_ready_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 tx_stat.tx_coding_ready == $past(tx_phy.pcs_ready)
        && tx_stat.tx_bond_done == $past(tx_phy.bond_done)
        && tx_stat.tx_cal_busy == $past(tx_phy.cal_busy)) else $error("tx mirror");
    bond_toggle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (tgl_cnt_reg >= lbsm_pkg::TOGGLE_LIMIT
         && win_cnt_reg != lbsm_pkg::TOGGLE_WIN_LAST) |=> tx_stat.tx_bond_unstable)
        else $error("toggle not flagged");
    frame_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (rx_phy.cdr_data_locked[0] && !rx_phy.sync_word_bad[0] && rx_phy.sync_word_seen[0])
        [*4] |=> rx_stat.rx_frame_lock[0]) else $error("frame lock late");
    frame_early_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(rx_stat.rx_frame_lock[0]) |-> $past(sync_cnt_reg[0]) == 3'h3)
        else $error("frame lock early");
    aligned_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_stat.rx_aligned |-> rx_stat.rx_block_frame_lock && rx_stat.rx_coding_ready
        && (&rx_stat.rx_cdr_data_locked)) else $error("aligned too soon");
    coding_fault_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (rx_phy.sync_hdr_err || rx_phy.mframe_len_err || rx_phy.checksum_fault)
        |=> rx_stat.rx_coding_fault) else $error("coding fault missed");
    checksum_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 rx_stat.rx_checksum_fault == $past(rx_phy.checksum_fault))
        else $error("checksum mirror");
    rx_misc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 rx_stat.rx_cal_busy == $past(rx_phy.cal_busy)
        && rx_stat.rx_coding_ready == $past(rx_phy.pcs_ready)
        && rx_stat.rx_cdr_data_locked == $past(rx_phy.cdr_data_locked))
        else $error("rx mirror");

    // ****************************************
    // Source side checks
    // ****************************************
    link_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_stat.link_up_tx |-> tx_state_reg == LBSM_TX_UP)
        else $error("link up outside up state");

    link_terms_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_stat.link_up_tx |-> tx_stat.tx_clk_locked && tx_stat.tx_coding_ready
        && tx_stat.tx_bond_done && !tx_stat.tx_cal_busy)
        else $error("link up with a bad term");

    pll_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !tx_phy.pll_locked |=> !tx_stat.link_up_tx)
        else $error("link up without clock lock");

    cal_blocks_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_phy.cal_busy |=> !tx_stat.link_up_tx)
        else $error("link up while calibrating");

    bond_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !tx_phy.bond_done |=> !tx_stat.link_up_tx)
        else $error("link up without bonding");

    link_init_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(tx_stat.link_up_tx) |-> tx_state_reg == LBSM_TX_INIT)
        else $error("link drop not back to init");

    win_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        win_cnt_reg <= lbsm_pkg::TOGGLE_WIN_LAST)
        else $error("window count out of range");

    unstable_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (tx_stat.tx_bond_unstable && win_cnt_reg != lbsm_pkg::TOGGLE_WIN_LAST)
        |=> tx_stat.tx_bond_unstable)
        else $error("unstable flag dropped early");

    // ****************************************
    // Sink side checks
    // ****************************************
    bfl_frames_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_stat.rx_block_frame_lock |-> (&rx_stat.rx_frame_lock))
        else $error("block frame lock without frame lock");

    bfl_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(&rx_phy.block_lock) |=> !rx_stat.rx_block_frame_lock)
        else $error("block frame lock without block lock");

    aligned_lanes_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_stat.rx_aligned |-> (&rx_stat.rx_frame_lock))
        else $error("aligned without all lanes");

    aligned_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rx_phy.pcs_ready |=> !rx_stat.rx_aligned)
        else $error("aligned without coding ready");

    frame_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rx_phy.cdr_data_locked[0] |=> !rx_stat.rx_frame_lock[0])
        else $error("frame lock kept without data lock");

    sync_bad_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_phy.sync_word_bad[2] |=> !rx_stat.rx_frame_lock[2])
        else $error("frame lock kept after bad word");

    cnt_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sync_cnt_reg[0] <= lbsm_pkg::SYNC_CNT_LOCK)
        else $error("sync count out of range");

    cdr_lane_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_stat.rx_frame_lock[1] |-> rx_stat.rx_cdr_data_locked[1])
        else $error("frame lock without data lock");

    fault_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(rx_phy.sync_hdr_err || rx_phy.mframe_len_err || rx_phy.checksum_fault)
        |=> !rx_stat.rx_coding_fault)
        else $error("coding fault without cause");

    bfl_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(rx_stat.rx_block_frame_lock) |-> $past(&rx_phy.block_lock))
        else $error("block frame lock rose early");

    // ****************************************
    // Cover points
    // ****************************************
    sync_bad_c:  cover property (@(posedge clk_sys) disable iff (!rstn)
        $fell(rx_stat.rx_frame_lock[2]));
    link_up_c:   cover property (@(posedge clk_sys) disable iff (!rstn) $rose(tx_stat.link_up_tx));
    aligned_c:   cover property (@(posedge clk_sys) disable iff (!rstn) $rose(rx_stat.rx_aligned));
    unstable_c:  cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tx_stat.tx_bond_unstable));
    link_drop_c: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(tx_stat.link_up_tx));

endmodule : lbsm_monitor

`default_nettype wire

// [lbsm_peer_model.sv]
// Far-side model: the peer lanes as seen through the receive transceivers.
// Assumes clk_sys and rstn of the monitor; outputs change just after an edge.
`timescale 1ns/1ps
`default_nettype none

module lbsm_peer_model (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        link_en,
    input  wire logic                        slow,
    input  wire logic [lbsm_pkg::LANES-1:0]  lane_en,
    output var  logic [lbsm_pkg::LANES-1:0]  cdr_locked,
    output var  logic [lbsm_pkg::LANES-1:0]  blk_lock,
    output var  logic [lbsm_pkg::LANES-1:0]  word_seen
);
    logic [1:0] gap_reg;

    // ****************************************
    // Lock and sync word pacing
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_reg    <= 2'h0;
            cdr_locked <= '0;
            blk_lock   <= '0;
            word_seen  <= '0;
        end else begin
            gap_reg    <= (gap_reg == 2'h2 || !slow) ? 2'h0 : gap_reg + 2'h1;
            cdr_locked <= link_en ? lane_en : '0;
            blk_lock   <= link_en ? lane_en : '0;
            word_seen  <= (link_en && gap_reg == 2'h0) ? lane_en : '0;
        end
    end
endmodule : lbsm_peer_model

`default_nettype wire

// [lbsm_pkg.sv]
// Package for the link bring-up status monitor: widths, counts, carriers.
// Assumes one 20 MHz clock and inputs synchronous to it.
package lbsm_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int          LANES           = 4;
    localparam int          CLK_MHZ         = 20;
    localparam int          SYNC_WORDS_LOCK = 4;
    localparam logic [2:0]  SYNC_CNT_W0     = 3'h0;
    localparam logic [2:0]  SYNC_CNT_LOCK   = 3'h4;
    localparam int          TOGGLE_WIN_NS   = 3200;
    localparam int          TOGGLE_WIN_CYC  = (TOGGLE_WIN_NS * CLK_MHZ) / 1000;
    localparam logic [7:0]  TOGGLE_WIN_LAST = 8'(TOGGLE_WIN_CYC - 1);
    localparam logic [3:0]  TOGGLE_LIMIT    = 4'h3;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic pll_locked;
        logic pcs_ready;
        logic bond_done;
        logic cal_busy;
    } lbsm_tx_phy_t;

    typedef struct packed {
        logic             pcs_ready;
        logic             cal_busy;
        logic             checksum_fault;
        logic             sync_hdr_err;
        logic             mframe_len_err;
        logic [LANES-1:0] cdr_data_locked;
        logic [LANES-1:0] block_lock;
        logic [LANES-1:0] sync_word_seen;
        logic [LANES-1:0] sync_word_bad;
    } lbsm_rx_phy_t;

    typedef struct packed {
        logic link_up_tx;
        logic tx_clk_locked;
        logic tx_coding_ready;
        logic tx_bond_done;
        logic tx_cal_busy;
        logic tx_bond_unstable;
    } lbsm_tx_stat_t;

    typedef struct packed {
        logic             rx_aligned;
        logic             rx_coding_ready;
        logic             rx_checksum_fault;
        logic             rx_coding_fault;
        logic             rx_block_frame_lock;
        logic             rx_cal_busy;
        logic [LANES-1:0] rx_frame_lock;
        logic [LANES-1:0] rx_cdr_data_locked;
    } lbsm_rx_stat_t;

endpackage : lbsm_pkg

// [link_bringup_status_monitor_tb_top.sv]
// Self-checking bench for the bring-up status monitor.
// Assumes lbsm_pkg, lbsm_monitor and lbsm_peer_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module link_bringup_status_monitor_tb_top;
    typedef struct {string nm; int due; logic [19:0] m; logic [19:0] e;} lbsm_note_t;
    logic                    clk_sys = 1'b0;
    logic                    rstn    = 1'b0;
    lbsm_pkg::lbsm_tx_phy_t  txd     = '0;
    lbsm_pkg::lbsm_rx_phy_t  rxd     = '0;
    lbsm_pkg::lbsm_rx_phy_t  rx_phy;
    lbsm_pkg::lbsm_tx_stat_t tx_stat;
    lbsm_pkg::lbsm_rx_stat_t rx_stat;
    logic                    en = 1'b0, slow = 1'b0;
    logic [3:0]              lane_en = 4'h0, cdr, blk, seen;
    logic [3:0]              bad     = 4'h0;
    logic [19:0]             obs;
    logic [31:0]             r;
    lbsm_note_t              q[$], n;
    int                      nn = 0, n_fail = 0, check_count = 0, seed = 34984;

    always #25 clk_sys = ~clk_sys;
    assign obs = {tx_stat, rx_stat};
    always_comb begin
        rx_phy = rxd;
        rx_phy.cdr_data_locked = cdr;
        rx_phy.block_lock = blk;
        rx_phy.sync_word_seen = seen;
        rx_phy.sync_word_bad = bad;
    end

    lbsm_monitor dut (.clk_sys(clk_sys), .rstn(rstn), .tx_phy(txd), .rx_phy(rx_phy),
        .tx_stat(tx_stat), .rx_stat(rx_stat));
    lbsm_peer_model peer (.clk_sys(clk_sys), .rstn(rstn), .link_en(en), .slow(slow),
        .lane_en(lane_en), .cdr_locked(cdr), .blk_lock(blk), .word_seen(seen));

    // ****************************************
    // Result watcher
    // ****************************************
    always @(negedge clk_sys) begin
        nn++;
        while (q.size() > 0 && q[0].due <= nn) begin
            n = q.pop_front();
            check_count++;
            if ((obs & n.m) !== (n.e & n.m)) begin
                n_fail++;
                $display("CHECK FAILED %s exp %h got %h", n.nm, n.e & n.m, obs & n.m);
            end
        end
    end

    task automatic exp_at(input string nm, input int d, input logic [19:0] m,
                          input logic [19:0] e);
        q.push_back('{nm, nn + d + 1, m, e});
    endtask : exp_at

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick

    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        tick(3000);
        n_fail++;
        $display("CHECK FAILED watchdog exp done got hang");
        stop_test();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        exp_at("reset", 0, 20'hfffff, 20'h0);
        tick(5);
        rstn <= 1'b1;
        tick(2);
        txd <= 4'he;
        exp_at("tx_early", 1, 20'hf8000, 20'h70000);
        exp_at("tx_up", 4, 20'h80000, 20'h80000);
        tick(5);
        txd <= 4'ha;
        exp_at("tx_drop", 1, 20'ha0000, 20'h0);
        tick(4);
        txd <= 4'he;
        exp_at("tx_reup", 4, 20'h80000, 20'h80000);
        tick(5);
        txd <= 4'hf;
        exp_at("tx_cal", 1, 20'h88000, 20'h08000);
        for (int i = 0; i < 10; i++) begin
            tick(1);
            txd.bond_done <= i[0];
        end
        exp_at("bond_unstable", 1, 20'h04000, 20'h04000);
        $display("test tx done");
        tick(1);
        rxd.pcs_ready <= 1'b1;
        en <= 1'b1;
        lane_en <= 4'hf;
        exp_at("frame_early", 4, 20'h022ff, 20'h0000f);
        exp_at("rx_lock", 12, 20'h033ff, 20'h032ff);
        tick(14);
        en <= 1'b0;
        tick(3);
        slow <= 1'b1;
        en <= 1'b1;
        exp_at("slow_early", 6, 20'h000f0, 20'h0);
        exp_at("slow_lock", 20, 20'h022f0, 20'h022f0);
        tick(22);
        lane_en <= 4'hd;
        exp_at("lane_lost", 4, 20'h022ff, 20'h000dd);
        tick(6);
        lane_en <= 4'hf;
        $display("test rx lock done");
        tick(10);
        bad <= 4'h4;
        exp_at("sync_bad", 1, 20'h000d0, 20'h00090);
        tick(1);
        bad <= 4'h0;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            r = $random(seed);
            txd <= r[3:0];
            {rxd.pcs_ready, rxd.cal_busy, rxd.checksum_fault} <= r[6:4];
            {rxd.sync_hdr_err, rxd.mframe_len_err} <= r[8:7];
            exp_at("mirror", 1, 20'h79d00, {1'b0, r[3:0], 2'b0, r[6], r[4],
                (r[4] | r[7] | r[8]), 1'b0, r[5], 8'h0});
        end
        $display("test status mirror done");
        tick(5);
        stop_test();
    end
endmodule : link_bringup_status_monitor_tb_top

`default_nettype wire
